// >>> common/pid_pkg.sv
// Constants and types of the process PID regulator.
// Assumes one 25 MHz clock and a plain register port.
package pid_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_NS = 10_000_000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int LOSS_TICKS_PER_UNIT = 10;
   // ==========================================================
   // Scaling, 0.1 percent per step, gain in 0.0001 steps
   localparam logic [15:0] PCT_FULL = 16'h03E8;
   localparam int PCT_DIV = 1000;
   localparam int KP_UNITY = 10000;
   localparam logic [15:0] FSRC_PID = 16'h0005;
   // ==========================================================
   // Setpoint and feedback source codes
   localparam logic [15:0] SP_KEYPAD = 16'h0000;
   localparam logic [15:0] SP_VOLTAGE = 16'h0001;
   localparam logic [15:0] SP_CURRENT = 16'h0002;
   localparam logic [15:0] SP_COMM = 16'h0003;
   localparam logic [15:0] SP_MULTI = 16'h0004;
   localparam logic [15:0] FB_VOLTAGE = 16'h0000;
   localparam logic [15:0] FB_CURRENT = 16'h0001;
   localparam logic [15:0] FB_SUM = 16'h0002;
   localparam logic [15:0] FB_COMM = 16'h0003;
   // ==========================================================
   // Register indices
   localparam int IDX_SP_SRC = 0;
   localparam int IDX_PRESET = 1;
   localparam int IDX_FB_SRC = 2;
   localparam int IDX_POL = 3;
   localparam int IDX_KP = 4;
   localparam int IDX_TI = 5;
   localparam int IDX_TD = 6;
   localparam int IDX_TS = 7;
   localparam int IDX_BAND = 8;
   localparam int IDX_THR = 9;
   localparam int IDX_LOSS_T = 10;
   localparam int IDX_FSRC = 11;
   localparam int IDX_MAXF = 12;
   localparam int NUM_CFG = 13;
   localparam logic [7:0] REG_STATUS = 8'h0D;
   localparam logic [7:0] REG_INT_CLR = 8'h0E;
   localparam logic [7:0] REG_INT_EN = 8'h0F;
   localparam logic [7:0] REG_FREQ = 8'h10;
   localparam logic [7:0] REG_FB = 8'h11;
   // Reset value, lower and upper bound of each setting
   localparam logic [15:0] CFG_RESET [NUM_CFG] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h000A,
      16'h0000, 16'h000A, 16'h0000, 16'h0000, 16'h000A, 16'h0000,
      16'h1388};
   localparam logic [15:0] CFG_MIN [NUM_CFG] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
      16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000};
   localparam logic [15:0] CFG_MAX [NUM_CFG] = '{
      16'h0004, 16'h03E8, 16'h0003, 16'h0001, 16'h2710, 16'h03E8,
      16'h03E8, 16'h2710, 16'h03E8, 16'h03E8, 16'h8CA0, 16'h000F,
      16'hFFFF};
   // Status bits
   localparam int ST_FAULT = 0;
   localparam int ST_STEP = 1;
   localparam int ST_W = 2;
   // ==========================================================
   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } bus_req_t;
endpackage : pid_pkg

// >>> verilog/process_pid_regulator.sv
// Process PID regulator: source selection, one PID step per period,
// dead band, output clamp and feedback loss detection.
// Assumes inputs in 0.1 percent units from logic on the same clock.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module process_pid_regulator #(
   parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic [15:0] i_analog_voltage_input,
   input wire logic [15:0] i_analog_current_input,
   input wire logic [15:0] i_comm_setpoint,
   input wire logic [15:0] i_multi_segment_setpoint,
   input wire logic [15:0] i_comm_feedback,
   output logic [15:0] o_freq_cmd,
   output logic o_feedback_loss_fault,
   output logic o_irq
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   pid_pkg::bus_req_t req;
   logic [15:0] cfg_reg [pid_pkg::NUM_CFG];
   logic [pid_pkg::ST_W-1:0] status_reg;
   logic [pid_pkg::ST_W-1:0] int_en_reg;
   logic [pid_pkg::ST_W-1:0] clr;
   logic [pid_pkg::ST_W-1:0] ev;
   logic [TW-1:0] tick_cnt_reg;
   logic tick;
   logic [15:0] samp_cnt_reg;
   logic step;
   logic active;
   logic [15:0] setpoint;
   logic [15:0] feedback;
   logic [16:0] fb_sum;
   logic signed [31:0] err;
   logic signed [31:0] abs_err;
   logic inband;
   logic signed [31:0] err_prev_reg;
   logic signed [31:0] acc_reg;
   logic signed [31:0] acc_next;
   logic signed [31:0] acc_lim;
   logic signed [31:0] p_term;
   logic signed [31:0] i_term;
   logic signed [31:0] d_term;
   logic signed [31:0] u_sum;
   logic [15:0] out_pct_next;
   logic [15:0] out_pct_reg;
   logic [19:0] loss_cnt_reg;
   logic [19:0] loss_lim;
   logic fb_low;
   logic fault_next;

   // ==========================================================
   // Register port
   assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

   // Settings are clipped to their legal range when written
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int k = 0; k < pid_pkg::NUM_CFG; k++) begin
            cfg_reg[k] <= pid_pkg::CFG_RESET[k];
         end
      end else if (req.wr && (int'(req.addr) < pid_pkg::NUM_CFG)) begin
         if (req.wdata > pid_pkg::CFG_MAX[int'(req.addr)]) begin
            cfg_reg[int'(req.addr)] <= pid_pkg::CFG_MAX[int'(req.addr)];
         end else if (req.wdata < pid_pkg::CFG_MIN[int'(req.addr)]) begin
            cfg_reg[int'(req.addr)] <= pid_pkg::CFG_MIN[int'(req.addr)];
         end else begin
            cfg_reg[int'(req.addr)] <= req.wdata;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         int_en_reg <= '0;
      end else if (req.wr && (req.addr == pid_pkg::REG_INT_EN)) begin
         int_en_reg <= req.wdata[pid_pkg::ST_W-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 16'h0000;
      end else if (req.rd) begin
         if (int'(req.addr) < pid_pkg::NUM_CFG) begin
            o_rdata <= cfg_reg[int'(req.addr)];
         end else begin
            case (req.addr)
               pid_pkg::REG_STATUS: o_rdata <= 16'(status_reg);
               pid_pkg::REG_INT_EN: o_rdata <= 16'(int_en_reg);
               pid_pkg::REG_FREQ: o_rdata <= o_freq_cmd;
               pid_pkg::REG_FB: o_rdata <= feedback;
               default: o_rdata <= 16'h0000;
            endcase
         end
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // ==========================================================
   // Interrupt status, a new event wins over a clear
   always_comb begin
      clr = '0;
      if (req.wr && (req.addr == pid_pkg::REG_INT_CLR)) begin
         clr = req.wdata[pid_pkg::ST_W-1:0];
      end
   end

   assign ev[pid_pkg::ST_FAULT] = fault_next && !o_feedback_loss_fault;
   assign ev[pid_pkg::ST_STEP] = step;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         status_reg <= '0;
      end else begin
         status_reg <= (status_reg & ~clr) | ev;
      end
   end

   assign o_irq = |(status_reg & int_en_reg);

   // ==========================================================
   // Time base: 10 ms tick and sampling period
   assign active = (cfg_reg[pid_pkg::IDX_FSRC] == pid_pkg::FSRC_PID);
   assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tick_cnt_reg <= '0;
      end else if (tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TW'(1);
      end
   end

   assign step = active && tick &&
      (samp_cnt_reg >= cfg_reg[pid_pkg::IDX_TS] - 16'h0001);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         samp_cnt_reg <= 16'h0000;
      end else if (!active || step) begin
         samp_cnt_reg <= 16'h0000;
      end else if (tick) begin
         samp_cnt_reg <= samp_cnt_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Setpoint and feedback selection, clipped to full scale
   function automatic logic [15:0] sat_pct(input logic [16:0] v);
      if (v > {1'b0, pid_pkg::PCT_FULL}) begin
         sat_pct = pid_pkg::PCT_FULL;
      end else begin
         sat_pct = v[15:0];
      end
   endfunction : sat_pct

   always_comb begin
      case (cfg_reg[pid_pkg::IDX_SP_SRC])
         pid_pkg::SP_VOLTAGE: setpoint = sat_pct({1'b0,
            i_analog_voltage_input});
         pid_pkg::SP_CURRENT: setpoint = sat_pct({1'b0,
            i_analog_current_input});
         pid_pkg::SP_COMM: setpoint = sat_pct({1'b0, i_comm_setpoint});
         pid_pkg::SP_MULTI: setpoint = sat_pct({1'b0,
            i_multi_segment_setpoint});
         default: setpoint = cfg_reg[pid_pkg::IDX_PRESET];
      endcase
   end

   assign fb_sum = {1'b0, i_analog_voltage_input} +
      {1'b0, i_analog_current_input};

   always_comb begin
      case (cfg_reg[pid_pkg::IDX_FB_SRC])
         pid_pkg::FB_CURRENT: feedback = sat_pct({1'b0,
            i_analog_current_input});
         pid_pkg::FB_SUM: feedback = sat_pct(fb_sum);
         pid_pkg::FB_COMM: feedback = sat_pct({1'b0, i_comm_feedback});
         default: feedback = sat_pct({1'b0, i_analog_voltage_input});
      endcase
   end

   // ==========================================================
   // Control step arithmetic
   always_comb begin
      if (cfg_reg[pid_pkg::IDX_POL][0]) begin
         err = $signed({16'h0000, feedback}) -
            $signed({16'h0000, setpoint});
      end else begin
         err = $signed({16'h0000, setpoint}) -
            $signed({16'h0000, feedback});
      end
   end

   assign abs_err = (err < 0) ? -err : err;
   assign inband = (abs_err <=
      $signed({16'h0000, cfg_reg[pid_pkg::IDX_BAND]}));

   assign p_term = ($signed({16'h0000, cfg_reg[pid_pkg::IDX_KP]}) * err)
      / pid_pkg::KP_UNITY;

   // Integral held as error times period; anti-windup at full scale
   assign acc_lim = $signed({16'h0000, cfg_reg[pid_pkg::IDX_TI]}) *
      pid_pkg::PCT_DIV;

   always_comb begin
      acc_next = acc_reg +
         err * $signed({16'h0000, cfg_reg[pid_pkg::IDX_TS]});
      if (acc_next > acc_lim) begin
         acc_next = acc_lim;
      end else if (acc_next < -acc_lim) begin
         acc_next = -acc_lim;
      end
   end

   assign i_term = acc_next /
      $signed({16'h0000, cfg_reg[pid_pkg::IDX_TI]});

   assign d_term = ((err - err_prev_reg) *
      $signed({16'h0000, cfg_reg[pid_pkg::IDX_TD]})) /
      $signed({16'h0000, cfg_reg[pid_pkg::IDX_TS]});

   assign u_sum = p_term + i_term + d_term;

   always_comb begin
      if (u_sum < 0) begin
         out_pct_next = 16'h0000;
      end else if (u_sum > $signed({16'h0000, pid_pkg::PCT_FULL})) begin
         out_pct_next = pid_pkg::PCT_FULL;
      end else begin
         out_pct_next = u_sum[15:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         out_pct_reg <= 16'h0000;
         acc_reg <= '0;
         err_prev_reg <= '0;
      end else if (!active) begin
         out_pct_reg <= 16'h0000;
         acc_reg <= '0;
         err_prev_reg <= '0;
      end else if (step) begin
         err_prev_reg <= err;
         if (!inband) begin
            out_pct_reg <= out_pct_next;
            acc_reg <= acc_next;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_freq_cmd <= 16'h0000;
      end else begin
         o_freq_cmd <= 16'((32'(out_pct_reg) *
            32'(cfg_reg[pid_pkg::IDX_MAXF])) / pid_pkg::PCT_DIV);
      end
   end

   // ==========================================================
   // Feedback loss detection, counted in 10 ms ticks
   assign fb_low = (feedback <= cfg_reg[pid_pkg::IDX_THR]);
   assign loss_lim = 20'(cfg_reg[pid_pkg::IDX_LOSS_T]) *
      20'(pid_pkg::LOSS_TICKS_PER_UNIT);
   assign fault_next = active && fb_low &&
      (loss_cnt_reg > loss_lim);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         loss_cnt_reg <= '0;
      end else if (!active || !fb_low) begin
         loss_cnt_reg <= '0;
      end else if (tick && (loss_cnt_reg != '1)) begin
         loss_cnt_reg <= loss_cnt_reg + 20'h00001;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_feedback_loss_fault <= 1'b0;
      end else begin
         o_feedback_loss_fault <= fault_next;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   a_inactive_idle: assert property (
      !active |=> (out_pct_reg == 16'h0000) && !o_feedback_loss_fault)
      else $error("regulator acted while not selected");
   a_out_clamp: assert property (
      out_pct_reg <= pid_pkg::PCT_FULL)
      else $error("output command above full scale");
   a_step_tick: assert property (
      step |-> tick ##1 !step [*8])
      else $error("control step off the tick");
   a_band_hold: assert property (
      active && step && inband |=> $stable(out_pct_reg))
      else $error("output moved inside dead band");
   a_keypad_src: assert property (
      cfg_reg[pid_pkg::IDX_SP_SRC] == pid_pkg::SP_KEYPAD
      |-> setpoint == cfg_reg[pid_pkg::IDX_PRESET])
      else $error("keypad setpoint not preset value");
   a_polarity: assert property (
      feedback > setpoint |->
      (err < 0) == !cfg_reg[pid_pkg::IDX_POL][0])
      else $error("error sign ignores polarity");
   a_integral_grows: assert property (
      active && step && !inband && err > 0 && acc_reg < acc_lim
      |=> acc_reg > $past(acc_reg))
      else $error("integral did not accumulate");
   a_loss_clear: assert property (
      !fb_low |=> loss_cnt_reg == '0 && !o_feedback_loss_fault)
      else $error("loss timer kept above threshold");
   a_loss_fault: assert property (
      active && fb_low && loss_cnt_reg > loss_lim
      |=> o_feedback_loss_fault)
      else $error("fault not raised after loss time");
   a_freq_scale: assert property (
      out_pct_reg == pid_pkg::PCT_FULL && $stable(out_pct_reg)
      |=> o_freq_cmd == $past(cfg_reg[pid_pkg::IDX_MAXF]))
      else $error("full output not at max frequency");

   // Counters, clipping and event capture
   a_status_wins: assert property (
      step |=> status_reg[pid_pkg::ST_STEP])
      else $error("step event lost to a clear");
   a_sample_count: assert property (
      active && tick && !step
      |=> samp_cnt_reg == $past(samp_cnt_reg) + 16'h0001)
      else $error("sampling counter missed a tick");
   a_src_scale: assert property (
      setpoint <= pid_pkg::PCT_FULL && feedback <= pid_pkg::PCT_FULL)
      else $error("selected value above full scale");
   a_step_update: assert property (
      active && step && !inband
      |=> out_pct_reg == $past(out_pct_next))
      else $error("output not updated outside dead band");
   a_integral_hold: assert property (
      active && step && inband |=> $stable(acc_reg))
      else $error("integral moved inside dead band");
   a_loss_count: assert property (
      active && fb_low && tick && loss_cnt_reg != '1
      |=> loss_cnt_reg == $past(loss_cnt_reg) + 20'h00001)
      else $error("loss timer missed a tick");
   a_loss_idle: assert property (
      !active |=> loss_cnt_reg == '0)
      else $error("loss timer ran while not selected");
   a_fault_low: assert property (
      o_feedback_loss_fault |-> $past(fb_low))
      else $error("fault without low feedback");
   a_freq_zero: assert property (
      out_pct_reg == 16'h0000 |=> o_freq_cmd == 16'h0000)
      else $error("zero output gave nonzero command");

   c_step_taken: cover property (active && step && !inband);
   c_band_hold: cover property (active && step && inband);
   c_fault: cover property ($rose(o_feedback_loss_fault));
   c_irq: cover property ($rose(o_irq));
   c_deriv: cover property (active && step && d_term != 0);
endmodule : process_pid_regulator

// >>> tb/pid_source_model.sv
// Model of the analog channels and communication link feeding the
// regulator. Values move only on a clock edge when the bench asks.
`timescale 1ns/1ps
module pid_source_model (
   input wire logic i_clk,
   output logic [15:0] o_voltage,
   output logic [15:0] o_current,
   output logic [15:0] o_comm_sp,
   output logic [15:0] o_multi_sp,
   output logic [15:0] o_comm_fb
);
   // ==========================================================
   // Channel values
   initial begin
      o_voltage = 16'h0000;
      o_current = 16'h0000;
      o_comm_sp = 16'h0000;
      o_multi_sp = 16'h0000;
      o_comm_fb = 16'h0000;
   end

   // The bench never feeds one channel to both sides of the loop
   task set(input logic [15:0] v, input logic [15:0] c,
      input logic [15:0] s, input logic [15:0] m, input logic [15:0] f);
      @(posedge i_clk);
      o_voltage <= v;
      o_current <= c;
      o_comm_sp <= s;
      o_multi_sp <= m;
      o_comm_fb <= f;
   endtask : set
endmodule : pid_source_model

// >>> tb/process_pid_regulator_test.sv
// Self-checking bench of the process PID regulator.
// Assumes a short tick (TC clocks) so that steps come fast.
`timescale 1ns/1ps
module process_pid_regulator_test;
   localparam int TC = 10;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] o_rdata, o_freq_cmd, av, ac, csp, msp, cfb;
   logic o_feedback_loss_fault, o_irq;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int t_irq = 0;

   always #20 i_clk = ~i_clk;

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         report_and_stop();
      end
   end

   pid_source_model u_src (.i_clk(i_clk), .o_voltage(av), .o_current(ac),
      .o_comm_sp(csp), .o_multi_sp(msp), .o_comm_fb(cfb));

   process_pid_regulator #(.TICK_CYCLES(TC)) u_dut (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_analog_voltage_input(av), .i_analog_current_input(ac),
      .i_comm_setpoint(csp), .i_multi_segment_setpoint(msp),
      .i_comm_feedback(cfb), .o_freq_cmd(o_freq_cmd),
      .o_feedback_loss_fault(o_feedback_loss_fault), .o_irq(o_irq));

   // ==========================================================
   // Shared tasks
   task report_and_stop();
      if (n_fail == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask : rd_chk

   task wait_irq();
      int k;
      #1;
      for (k = 0; k < 100 && o_irq !== 1'b1; k++) begin
         @(posedge i_clk);
         #1;
      end
      chk(16'(o_irq), 16'h0001);
      t_irq = cyc;
   endtask : wait_irq

   // Regulator off, pending events cleared, output at zero
   task idle();
      wr(8'h0B, 16'h0000);
      wr(pid_pkg::REG_INT_CLR, 16'h0003);
      #1;
      chk(o_freq_cmd, 16'h0000);
   endtask : idle

   // Regulator on, first control step, command compared
   task fire(input logic [15:0] exp);
      wr(8'h0B, pid_pkg::FSRC_PID);
      wait_irq();
      @(posedge i_clk);
      #1;
      chk(o_freq_cmd, exp);
   endtask : fire

   // ==========================================================
   // Main sequence
   initial begin
      logic [15:0] spv [5];
      logic [15:0] fbv [4];
      int i;
      spv = '{16'h012C, 16'h00C8, 16'h0190, 16'h0258, 16'h02BC};
      fbv = '{16'h00C8, 16'h0190, 16'h0258, 16'h0000};
      repeat (20) @(posedge i_clk);
      i_rstn <= 1'b1;
      // Reset values, unmapped, write-only and read-only places
      for (i = 0; i < pid_pkg::NUM_CFG; i++) begin
         rd_chk(8'(i), pid_pkg::CFG_RESET[i]);
      end
      rd_chk(pid_pkg::REG_INT_CLR, 16'h0000);
      rd_chk(8'h20, 16'h0000);
      wr(pid_pkg::REG_FREQ, 16'h1234);
      rd_chk(pid_pkg::REG_FREQ, 16'h0000);
      // Settings are clipped to their ranges
      wr(8'h04, 16'hFFFF);
      rd_chk(8'h04, 16'h2710);
      wr(8'h05, 16'h0000);
      rd_chk(8'h05, 16'h0001);
      wr(8'h00, 16'h0009);
      rd_chk(8'h00, 16'h0004);
      // Unity proportional path, tiny integral, step every tick
      wr(8'h05, 16'h03E8);
      wr(8'h07, 16'h0001);
      wr(8'h0C, 16'h07D0);
      wr(8'h02, pid_pkg::FB_COMM);
      wr(8'h01, 16'h012C);
      wr(pid_pkg::REG_INT_EN, 16'h0002);
      u_src.set(16'h00C8, 16'h0190, 16'h0258, 16'h02BC, 16'h0000);
      // Every setpoint source, command is twice the percent
      for (i = 0; i < 5; i++) begin
         idle();
         wr(8'h00, 16'(i));
         fire(16'(2 * spv[i]));
      end
      // Step spacing is one sampling period
      i = t_irq;
      wr(pid_pkg::REG_INT_CLR, 16'h0002);
      wait_irq();
      chk(16'(t_irq - i), 16'(TC));
      // Masked event keeps the interrupt low
      wr(pid_pkg::REG_INT_EN, 16'h0000);
      #1;
      chk(16'(o_irq), 16'h0000);
      wr(pid_pkg::REG_INT_EN, 16'h0002);
      // Polarity with feedback above setpoint
      idle();
      wr(8'h00, pid_pkg::SP_KEYPAD);
      u_src.set(16'h00C8, 16'h0190, 16'h0258, 16'h02BC, 16'h01F4);
      fire(16'h0000);
      idle();
      wr(8'h03, 16'h0001);
      fire(16'h0190);
      idle();
      wr(8'h03, 16'h0000);
      u_src.set(16'h00C8, 16'h0190, 16'h0258, 16'h02BC, 16'h0000);
      // Full error, short integral time: clamped at full frequency
      wr(8'h01, 16'h03E8);
      wr(8'h05, 16'h0001);
      fire(16'h07D0);
      // Error inside dead band leaves output untouched
      idle();
      wr(8'h05, 16'h03E8);
      wr(8'h01, 16'h012C);
      wr(8'h08, 16'h01F4);
      fire(16'h0000);
      wr(8'h08, 16'h0000);
      // Derivative acts on a change of error, not on its size
      idle();
      wr(8'h04, 16'h0000);
      wr(8'h06, 16'h0001);
      fire(16'h0258);
      wr(pid_pkg::REG_INT_CLR, 16'h0002);
      wait_irq();
      @(posedge i_clk);
      #1;
      chk(o_freq_cmd, 16'h0000);
      wr(8'h06, 16'h0000);
      // Every feedback source
      for (i = 0; i < 4; i++) begin
         wr(8'h02, 16'(i));
         rd_chk(pid_pkg::REG_FB, fbv[i]);
      end
      // Feedback loss: ten ticks allowed, eleventh faults
      idle();
      wr(8'h02, pid_pkg::FB_VOLTAGE);
      wr(8'h09, 16'h0064);
      wr(8'h0A, 16'h0001);
      wr(pid_pkg::REG_INT_EN, 16'h0001);
      u_src.set(16'h01F4, 16'h0190, 16'h0258, 16'h02BC, 16'h0000);
      wr(8'h0B, pid_pkg::FSRC_PID);
      u_src.set(16'h0032, 16'h0190, 16'h0258, 16'h02BC, 16'h0000);
      repeat (90) @(posedge i_clk);
      chk(16'(o_feedback_loss_fault), 16'h0000);
      wait_irq();
      repeat (2) @(posedge i_clk);
      chk(16'(o_feedback_loss_fault), 16'h0001);
      rd_chk(pid_pkg::REG_STATUS, 16'h0003);
      u_src.set(16'h01F4, 16'h0190, 16'h0258, 16'h02BC, 16'h0000);
      repeat (3) @(posedge i_clk);
      chk(16'(o_feedback_loss_fault), 16'h0000);
      wr(pid_pkg::REG_INT_CLR, 16'h0001);
      #1;
      chk(16'(o_irq), 16'h0000);
      report_and_stop();
   end
endmodule : process_pid_regulator_test
